// *** verification/rpm_config_regs_properties.sv ***
/*
 * Port-level checker for the power meter register bank.
 * Assumes it is bound to rpm_config_regs and sees only its ports.
 */
// ****************************************************************
// Checker
// ****************************************************************
module rpm_checker (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata_q,
	input wire [15:0] sample_in,
	input wire sample_valid,
	input wire [7:0] sync_in,
	input wire test_enable,
	input wire [15:0] delayed_out_q,
	input wire [15:0] test_out_q,
	input wire meas_done_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
		else $error("read data not zero outside read slot");
	a_umsb_pad: assert property (reg_rd && reg_addr == 8'h23 |=>
		reg_rdata_q[15:10] == 6'h00) else $error("result top pad set");
	a_dly_unused: assert property (reg_rd && reg_addr == 8'h16 |=>
		!reg_rdata_q[15]) else $error("start delay bit 15 set");
	a_cfg_unused: assert property (reg_rd && reg_addr == 8'h17 |=>
		reg_rdata_q[5:3] == 3'h0) else $error("config unused bits set");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h23 |=>
		reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
	a_test_off: assert property (!test_enable |=> test_out_q == 16'h0000)
		else $error("test output active while disabled");
	a_wr_visible: assert property (reg_wr && reg_addr == 8'h18 ##1 !reg_wr
		##1 reg_rd && reg_addr == 8'h18 |=> reg_rdata_q == $past(reg_wdata, 3))
		else $error("test value readback differs");
	a_done_single: assert property (meas_done_q |=> !meas_done_q)
		else $error("done pulse longer than one cycle");
endmodule // rpm_checker

bind rpm_config_regs rpm_checker i_chk (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sample_in(sample_in),
	.sample_valid(sample_valid), .sync_in(sync_in),
	.test_enable(test_enable), .delayed_out_q(delayed_out_q),
	.test_out_q(test_out_q), .meas_done_q(meas_done_q));

// *** verification/rpm_config_regs_tb.sv ***
/*
 * Self-checking bench for the power meter register bank.
 * Assumes the design answers reads one cycle after the read strobe.
 */
// ****************************************************************
// Bench
// ****************************************************************
module rpm_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic sample_valid = 1'b0, test_enable = 1'b0;
	logic [7:0] reg_addr = 8'h00, sync_in = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, sample_in = 16'h0000;
	wire [15:0] rdata, dout, tout;
	wire done;
	int n_errors = 0, checks_done = 0, cyc = 0, i;
	logic [7:0] al [9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
		8'h20, 8'h21, 8'h22, 8'h23};
	always #20 sys_clk = ~sys_clk;
	rpm_config_regs i_dut (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(rdata), .sample_in(sample_in),
		.sample_valid(sample_valid), .sync_in(sync_in),
		.test_enable(test_enable), .delayed_out_q(dout),
		.test_out_q(tout), .meas_done_q(done));
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata, exp);
	endtask
	// Leaves in i the count of falling edges up to the done pulse
	task wait_done;
		for (i = 1; i < 40; i++)
		begin
			@(negedge sys_clk);
			if (done === 1'b1)
				break;
		end
	endtask
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			complete_run;
		end
	end
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 9; i++)
			rd(al[i], 16'h0000);
		$display("test reset values done");
		wr(8'h14, 16'hFFFF);
		rd(8'h14, 16'hFFFF);
		wr(8'h15, 16'hFFFF);
		rd(8'h15, 16'hFFFF);
		wr(8'h16, 16'hFFFF);
		rd(8'h16, 16'h7FFF);
		wr(8'h17, 16'hFFFF);
		rd(8'h17, 16'hFFC7);
		wr(8'h18, 16'hA5C3);
		rd(8'h18, 16'hA5C3);
		wr(8'h20, 16'hFFFF);
		rd(8'h20, 16'h0000);
		rd(8'h30, 16'h0000);
		$display("test field access done");
		@(posedge sys_clk) test_enable <= 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) chk(tout, 16'hA5C3);
		@(posedge sys_clk) test_enable <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) chk(tout, 16'h0000);
		$display("test self-test source done");
		// Eight samples of 3 give 72; eight of -32768 give 2**33, which
		// lands in the third word; the start delay stretches the time
		wr(8'h14, 16'h0001);
		wr(8'h15, 16'h0000);
		wr(8'h17, 16'h0001);
		for (int d = 0; d < 2; d++)
		begin
			wr(8'h16, 16'(d));
			@(posedge sys_clk);
			sample_in <= (d == 1) ? 16'h8000 : 16'h0003;
			sample_valid <= 1'b1;
			sync_in <= 8'h02;
			@(posedge sys_clk) sync_in <= 8'h00;
			wait_done;
			chk(16'(i), 16'(10 + 8 * d));
			@(posedge sys_clk) sample_valid <= 1'b0;
			// Before a new low-word read the old snapshot must still show
			if (d == 1)
				rd(8'h22, 16'h0000);
			rd(8'h20, (d == 1) ? 16'h0000 : 16'h0048);
			rd(8'h21, 16'h0000);
			rd(8'h22, (d == 1) ? 16'h0002 : 16'h0000);
			rd(8'h23, 16'h0000);
		end
		$display("test power window done");
		// An interval of two units repeats the window every 16 samples
		wr(8'h15, 16'h0002);
		wr(8'h16, 16'h0000);
		@(posedge sys_clk);
		sample_valid <= 1'b1;
		sync_in <= 8'h02;
		@(posedge sys_clk) sync_in <= 8'h00;
		wait_done;
		chk(16'(i), 16'h000A);
		wait_done;
		chk(16'(i), 16'h0010);
		@(posedge sys_clk) sample_valid <= 1'b0;
		$display("test interval repeat done");
		// Offset loads only with the selected sync; the third pass drives
		// every other sync line, so the offset of two must stay
		for (int p = 0; p < 3; p++)
		begin
			wr(8'h16, (p == 1) ? 16'h0400 : 16'h0000);
			for (int k = 1; k <= 10; k++)
			begin
				@(posedge sys_clk);
				sample_in <= 16'(k);
				sample_valid <= 1'b1;
				sync_in <= (p < 2) ? 8'h02 : 8'hFD;
			end
			@(posedge sys_clk) sample_valid <= 1'b0;
			sync_in <= 8'h00;
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk(dout, (p == 0) ? 16'h0009 : 16'h0007);
		end
		$display("test delay line done");
		// A second reset clears every register and the stored result
		@(posedge sys_clk) rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 9; i++)
			rd(al[i], 16'h0000);
		$display("test second reset done");
		complete_run;
	end
endmodule // rpm_config_regs_tb

// *** verilog/rpm_config_regs.v ***
/*
 * Receive power meter configuration and result registers, with the meter
 * sequencer, the 64-sample variable delay line and the self-test source.
 * Assumes samples and sync lines synchronous to sys_clk, and a bus master
 * that issues one-cycle read or write strobes, never both at once.
 */

`include "rpm_regs.vh"

module rpm_config_regs (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	input wire [15:0] sample_in,
	input wire sample_valid,
	input wire [7:0] sync_in,
	input wire test_enable,
	output reg [15:0] delayed_out_q,
	output reg [15:0] test_out_q,
	output reg meas_done_q
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function [23:0] rpm_units8;
		input [20:0] v;
		begin
			rpm_units8 = {v, 3'h0};
		end
	endfunction

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	reg [15:0] win_low_q;
	reg [15:0] int_low_q;
	reg [8:0] dly_q;
	reg [5:0] dln_q;
	reg [4:0] winh_q;
	reg [4:0] inth_q;
	reg [2:0] ssel_q;
	reg [15:0] tst_q;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			win_low_q <= `RPM_RST16;
			int_low_q <= `RPM_RST16;
			dly_q <= `RPM_RST9;
			dln_q <= `RPM_RST6;
			winh_q <= `RPM_RST5;
			inth_q <= `RPM_RST5;
			ssel_q <= `RPM_RST3;
			tst_q <= `RPM_RST16;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`RPM_ADDR_WIN_LOW:
					win_low_q <= reg_wdata;
				`RPM_ADDR_INT_LOW:
					int_low_q <= reg_wdata;
				`RPM_ADDR_START_DLY:
				begin
					dly_q <= reg_wdata[`RPM_DLY_MSB:`RPM_DLY_LSB];
					dln_q <= reg_wdata[`RPM_DLN_MSB:`RPM_DLN_LSB];
				end
				`RPM_ADDR_CONFIG:
				begin
					winh_q <= reg_wdata[`RPM_WINH_MSB:`RPM_WINH_LSB];
					inth_q <= {reg_wdata[`RPM_INTH_MSB:`RPM_INTH_LSB],
						reg_wdata[`RPM_INTM_MSB:`RPM_INTM_LSB]};
					ssel_q <= reg_wdata[`RPM_SSEL_MSB:`RPM_SSEL_LSB];
				end
				`RPM_ADDR_TEST_VAL:
					tst_q <= reg_wdata;
				default:
					tst_q <= tst_q;
			endcase
		end
	end

	// ****************************************************************
	// Sync selection and lengths in samples
	// ****************************************************************
	wire sync_sel;
	wire [23:0] win_len;
	wire [23:0] int_len;
	wire [23:0] dly_len;

	assign sync_sel = sync_in[ssel_q];
	assign win_len = rpm_units8({winh_q, win_low_q});
	assign int_len = rpm_units8({inth_q, int_low_q});
	assign dly_len = rpm_units8({12'h000, dly_q});

	// ****************************************************************
	// Power meter sequencer
	// ****************************************************************
	// A new sync re-arms the meter even mid-window; the partial sum is
	// dropped so a result never mixes two timing references.
	reg [1:0] state_q;
	reg [23:0] cnt_q;
	reg [23:0] per_q;
	reg [57:0] acc_q;
	reg [57:0] result_q;
	wire signed [15:0] s_w;
	wire signed [31:0] prod_w;
	wire [57:0] acc_next;

	assign s_w = sample_in;
	assign prod_w = s_w * s_w;
	assign acc_next = acc_q + {26'h000_0000, prod_w};

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= `RPM_ST_IDLE;
			cnt_q <= `RPM_ZERO24;
			per_q <= `RPM_ZERO24;
			acc_q <= `RPM_RST_RES;
			result_q <= `RPM_RST_RES;
			meas_done_q <= 1'b0;
		end
		else
		begin
			meas_done_q <= 1'b0;
			if (sync_sel && win_len != `RPM_ZERO24)
			begin
				state_q <= `RPM_ST_DELAY;
				cnt_q <= `RPM_ZERO24;
			end
			else
			begin
				case (state_q)
					`RPM_ST_IDLE:
						state_q <= `RPM_ST_IDLE;
					`RPM_ST_DELAY:
						if (sample_valid)
						begin
							if (cnt_q == dly_len)
							begin
								state_q <= `RPM_ST_MEAS;
								cnt_q <= `RPM_ZERO24;
								per_q <= `RPM_ZERO24;
								acc_q <= `RPM_RST_RES;
							end
							else
								cnt_q <= cnt_q + `RPM_ONE24;
						end
					`RPM_ST_MEAS:
						if (sample_valid)
						begin
							cnt_q <= cnt_q + `RPM_ONE24;
							per_q <= per_q + `RPM_ONE24;
							acc_q <= acc_next;
							if (cnt_q + `RPM_ONE24 == win_len)
							begin
								result_q <= acc_next;
								meas_done_q <= 1'b1;
								if (int_len != `RPM_ZERO24)
									state_q <= `RPM_ST_WAIT;
								else
									state_q <= `RPM_ST_IDLE;
							end
						end
					`RPM_ST_WAIT:
						if (sample_valid)
						begin
							// Interval shorter than the window restarts at once
							if (per_q + `RPM_ONE24 >= int_len)
							begin
								state_q <= `RPM_ST_MEAS;
								cnt_q <= `RPM_ZERO24;
								per_q <= `RPM_ZERO24;
								acc_q <= `RPM_RST_RES;
							end
							else
								per_q <= per_q + `RPM_ONE24;
						end
					default:
						state_q <= `RPM_ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Variable delay line
	// ****************************************************************
	// The offset only moves on the chosen sync, so software can change it
	// at any time without a glitch in the delayed stream.
	reg [15:0] dline_mem [0:63];
	reg [5:0] wptr_q;
	reg [5:0] off_q;
	wire [5:0] rptr;

	assign rptr = wptr_q - `RPM_ONE6 - off_q;

	always @(posedge sys_clk)
	begin
		if (sample_valid)
			dline_mem[wptr_q] <= sample_in;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wptr_q <= `RPM_RST6;
			off_q <= `RPM_RST6;
			delayed_out_q <= `RPM_RST16;
		end
		else
		begin
			if (sync_sel)
				off_q <= dln_q;
			if (sample_valid)
			begin
				wptr_q <= wptr_q + `RPM_ONE6;
				delayed_out_q <= dline_mem[rptr];
			end
		end
	end

	// ****************************************************************
	// Self-test source
	// ****************************************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			test_out_q <= `RPM_RST16;
		else if (test_enable)
			test_out_q <= tst_q;
		else
			test_out_q <= `RPM_RST16;
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Reading the low word freezes the whole result; the upper words come
	// from that copy, so a window ending mid-sequence cannot tear it.
	reg [57:0] shadow_q;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata_q <= `RPM_RST16;
			shadow_q <= `RPM_RST_RES;
		end
		else if (reg_rd)
		begin
			case (reg_addr)
				`RPM_ADDR_WIN_LOW:
					reg_rdata_q <= win_low_q;
				`RPM_ADDR_INT_LOW:
					reg_rdata_q <= int_low_q;
				`RPM_ADDR_START_DLY:
					reg_rdata_q <= {1'b0, dln_q, dly_q};
				`RPM_ADDR_CONFIG:
					reg_rdata_q <= {winh_q, inth_q[4:2], inth_q[1:0],
						3'h0, ssel_q};
				`RPM_ADDR_TEST_VAL:
					reg_rdata_q <= tst_q;
				`RPM_ADDR_RES_LOW:
				begin
					reg_rdata_q <= result_q[15:0];
					shadow_q <= result_q;
				end
				`RPM_ADDR_RES_MID:
					reg_rdata_q <= shadow_q[31:16];
				`RPM_ADDR_RES_LMSB:
					reg_rdata_q <= shadow_q[47:32];
				`RPM_ADDR_RES_UMSB:
					reg_rdata_q <= {6'h00, shadow_q[57:48]};
				default:
					reg_rdata_q <= `RPM_RST16;
			endcase
		end
		else
			reg_rdata_q <= `RPM_RST16;
	end

endmodule // rpm_config_regs

// *** verilog/rpm_regs.vh ***
/*
 * Register offsets, field positions, reset values and state codes of the
 * receive power meter configuration bank.
 * Assumes an 8-bit word address on a plain strobe port with 16-bit data.
 */
`ifndef RPM_REGS_VH
`define RPM_REGS_VH

// ****************************************************************
// Register word addresses
// ****************************************************************
`define RPM_ADDR_WIN_LOW 8'h14
`define RPM_ADDR_INT_LOW 8'h15
`define RPM_ADDR_START_DLY 8'h16
`define RPM_ADDR_CONFIG 8'h17
`define RPM_ADDR_TEST_VAL 8'h18
`define RPM_ADDR_RES_LOW 8'h20
`define RPM_ADDR_RES_MID 8'h21
`define RPM_ADDR_RES_LMSB 8'h22
`define RPM_ADDR_RES_UMSB 8'h23

// ****************************************************************
// Field positions
// ****************************************************************
`define RPM_DLY_MSB 8
`define RPM_DLY_LSB 0
`define RPM_DLN_MSB 14
`define RPM_DLN_LSB 9
`define RPM_WINH_MSB 15
`define RPM_WINH_LSB 11
`define RPM_INTH_MSB 10
`define RPM_INTH_LSB 8
`define RPM_INTM_MSB 7
`define RPM_INTM_LSB 6
`define RPM_SSEL_MSB 2
`define RPM_SSEL_LSB 0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RPM_RST16 16'h0000
`define RPM_RST9 9'h000
`define RPM_RST6 6'h00
`define RPM_RST5 5'h00
`define RPM_RST3 3'h0
`define RPM_RST_RES 58'h000_0000_0000_0000
`define RPM_ZERO24 24'h00_0000
`define RPM_ONE24 24'h00_0001
`define RPM_ONE6 6'h01

// ****************************************************************
// Meter sequencer states
// ****************************************************************
`define RPM_ST_IDLE 2'h0
`define RPM_ST_DELAY 2'h1
`define RPM_ST_MEAS 2'h2
`define RPM_ST_WAIT 2'h3

`endif
